// ---- hw/guest_entry_late_stage_sequencer.sv ----
`timescale 1ns/100ps
`default_nettype none
module guest_entry_late_stage_sequencer
  import gels_pkg::*;
#(
  parameter int LMA_BIT = 10
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Avalon-MM register slave.
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Control-structure memory reads.
  output logic mem_rd_req,
  output logic [63:0] mem_rd_addr,
  input wire logic mem_rd_ack,
  input wire logic [63:0] mem_rd_data,
  // Guest-state pointer entry fields.
  input wire logic [63:0] guest_pte_field [PTE_COUNT],
  // Loaded pointer table entries.
  output logic [63:0] pointer_table_entry [PTE_COUNT],
  output logic pte_guest_phys,
  // Translation cache control.
  output logic tlb_inv_tag_zero,
  output logic [15:0] tlb_inv_tag,
  output logic [39:0] tlb_inv_root,
  output logic tlb_flush_all,
  // Virtual interrupt state.
  output logic [7:0] requesting_virq_vector,
  output logic [7:0] servicing_virq_vector,
  output logic processor_priority_update,
  output logic virq_evaluate,
  // Address-range monitoring.
  output logic monitor_clear,
  // Register write port.
  output logic msr_wr_valid,
  output logic [31:0] msr_wr_index,
  output logic [63:0] msr_wr_data,
  input wire logic msr_wr_ready,
  input wire logic msr_smm_only,
  input wire logic msr_forbidden,
  input wire logic msr_gp_fault,
  input wire logic msr_needs_flush,
  input wire logic msr_is_mode_reg,
  input wire logic [63:0] msr_cur_value,
  // Event delivery.
  output logic deliver_req,
  output logic [7:0] deliver_vector,
  output logic [2:0] deliver_type,
  input wire logic deliver_done,
  input wire logic nested_valid,
  input wire logic [4:0] nested_vector,
  input wire exc_class_t nested_class,
  input wire exc_class_t inj_class,
  output logic nested_deliver,
  output logic double_fault,
  output logic guest_exit,
  output logic single_step_trap,
  output logic host_state_load
);
  typedef enum logic [3:0] {
    S_IDLE, S_PTE, S_TLB, S_VIRQ_LD, S_VIRQ_PPR, S_VIRQ_EVAL, S_MON,
    S_LIST_LO, S_LIST_HI, S_CHECK, S_WRITE, S_FLUSH, S_EVENT, S_DELIVER, S_HOST, S_FINISH
  } state_t;

  function automatic logic is_vectored(input logic [2:0] t);
    is_vectored = (t == EV_EXT) || (t == EV_NMI) || (t == EV_HWEXC)
               || (t == EV_SWINT) || (t == EV_PRIVSW) || (t == EV_SWEXC);
  endfunction : is_vectored

  state_t state;
  state_t next_state;
  logic [6:0] ctrl;
  logic [4:0] status;
  logic [63:0] ptb;
  logic [63:0] list_base;
  logic [31:0] list_cnt;
  logic [31:0] event_info;
  logic [63:0] slp;
  logic [15:0] irq_stat;
  logic [31:0] exc_map;
  logic [31:0] fail_idx;
  logic [1:0] pte_i;
  logic [31:0] list_i;
  logic [63:0] ent_lo;
  logic [63:0] ent_hi;
  logic flush_due;
  logic ack;

  entry_check_if chk_bus (.clk(clk), .srst(srst));
  list_entry_checker u_chk (.c(chk_bus));
  assign chk_bus.index = ent_lo[31:0];
  assign chk_bus.reserved = ent_lo[63:32];
  assign chk_bus.in_smm = ctrl[B_SMM];
  assign chk_bus.smm_only = msr_smm_only;
  assign chk_bus.forbidden = msr_forbidden;
  assign chk_bus.gp_fault = msr_gp_fault;

  // Register decode.
  wire bus_req = avs_read || avs_write;
  wire wr_now = avs_write && ack;
  wire wr_ctrl = wr_now && (avs_address == OFS_CTRL);
  wire wr_stat = wr_now && (avs_address == OFS_STATUS);
  wire start = wr_ctrl && avs_writedata[B_START] && (state == S_IDLE);
  // Start comes in the same write as the mode bits, so the paging decision reads the incoming word.
  wire [6:0] ctrl_now = wr_ctrl ? {avs_writedata[6:1], 1'b0} : ctrl;
  wire pae_mode = ctrl_now[B_PAE] && !ctrl_now[B_LMA];
  wire [2:0] ev_type = event_info[EV_TYPE_LSB +: 3];
  wire [7:0] ev_vec = event_info[7:0];
  wire ev_valid = event_info[EV_VALID];
  wire list_end = (list_i == list_cnt);
  wire [63:0] list_addr = list_base + (LIST_STRIDE * {32'h0000_0000, list_i});
  wire exc_hit = exc_map[nested_vector];
  wire entry_done = (state == S_FINISH);
  wire entry_fail = (state == S_HOST);
  wire event_exit = (state == S_DELIVER) && deliver_done && nested_valid && exc_hit;
  // The mode flag is kept as it stands, since ordinary writes cannot change it either.
  wire [63:0] wr_value = msr_is_mode_reg
    ? ((ent_hi & ~(64'h1 << LMA_BIT)) | (msr_cur_value & (64'h1 << LMA_BIT)))
    : ent_hi;

  assign avs_waitrequest = bus_req && !ack;

  always_ff @(posedge clk)
  begin
    if (srst || ack)
      ack <= 1'b0;
    else
      ack <= bus_req;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && !ack)
    begin
      unique case (avs_address)
        OFS_CTRL: avs_readdata <= {25'h000_0000, ctrl};
        OFS_STATUS: avs_readdata <= {27'h000_0000, status};
        OFS_PTB_LO: avs_readdata <= ptb[31:0];
        OFS_PTB_HI: avs_readdata <= ptb[63:32];
        OFS_LIST_LO: avs_readdata <= list_base[31:0];
        OFS_LIST_HI: avs_readdata <= list_base[63:32];
        OFS_LIST_CNT: avs_readdata <= list_cnt;
        OFS_EVENT: avs_readdata <= event_info;
        OFS_SLP_LO: avs_readdata <= slp[31:0];
        OFS_SLP_HI: avs_readdata <= slp[63:32];
        OFS_IRQ_STAT: avs_readdata <= {16'h0000, irq_stat};
        OFS_EXC_MAP: avs_readdata <= exc_map;
        OFS_FAIL_IDX: avs_readdata <= fail_idx;
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl <= CTRL_RST;
      ptb <= 64'h0;
      list_base <= 64'h0;
      list_cnt <= 32'h0;
      event_info <= 32'h0;
      slp <= 64'h0;
      irq_stat <= 16'h0;
      exc_map <= 32'h0;
    end
    else if (wr_now && state == S_IDLE)
    begin
      if (avs_address == OFS_CTRL) ctrl <= {avs_writedata[6:1], 1'b0};
      if (avs_address == OFS_PTB_LO) ptb[31:0] <= avs_writedata;
      if (avs_address == OFS_PTB_HI) ptb[63:32] <= avs_writedata;
      if (avs_address == OFS_LIST_LO) list_base[31:0] <= avs_writedata;
      if (avs_address == OFS_LIST_HI) list_base[63:32] <= avs_writedata;
      if (avs_address == OFS_LIST_CNT) list_cnt <= avs_writedata;
      if (avs_address == OFS_EVENT) event_info <= avs_writedata;
      if (avs_address == OFS_SLP_LO) slp[31:0] <= avs_writedata;
      if (avs_address == OFS_SLP_HI) slp[63:32] <= avs_writedata;
      if (avs_address == OFS_IRQ_STAT) irq_stat <= avs_writedata[15:0];
      if (avs_address == OFS_EXC_MAP) exc_map <= avs_writedata;
    end
  end

  // Sticky result bits: hardware set wins over a write-one clear in the same cycle.
  always_ff @(posedge clk)
  begin
    if (srst)
      status <= 5'h00;
    else
    begin
      status[ST_BUSY] <= (next_state != S_IDLE);
      status[ST_DONE] <= entry_done || entry_fail || (status[ST_DONE] && !(wr_stat && avs_writedata[ST_DONE]));
      status[ST_FAIL] <= entry_fail || (status[ST_FAIL] && !(wr_stat && avs_writedata[ST_FAIL]));
      status[ST_SSTEP] <= single_step_trap || (status[ST_SSTEP] && !(wr_stat && avs_writedata[ST_SSTEP]));
      status[ST_EXIT] <= event_exit || (status[ST_EXIT] && !(wr_stat && avs_writedata[ST_EXIT]));
    end
  end

  always_comb
  begin
    next_state = state;
    unique case (state)
      S_IDLE: if (start) next_state = pae_mode ? S_PTE : S_TLB;
      S_PTE: if (ctrl[B_SLT] || (mem_rd_ack && pte_i == 2'(PTE_COUNT - 1))) next_state = S_TLB;
      S_TLB: next_state = ctrl[B_VIRQ] ? S_VIRQ_LD : S_MON;
      S_VIRQ_LD: next_state = S_VIRQ_PPR;
      S_VIRQ_PPR: next_state = S_VIRQ_EVAL;
      S_VIRQ_EVAL: next_state = S_MON;
      S_MON: next_state = S_LIST_LO;
      S_LIST_LO: if (list_end) next_state = S_FLUSH; else if (mem_rd_ack) next_state = S_LIST_HI;
      S_LIST_HI: if (mem_rd_ack) next_state = S_CHECK;
      S_CHECK: next_state = chk_bus.reject ? S_HOST : S_WRITE;
      S_WRITE: if (msr_wr_ready) next_state = S_LIST_LO;
      S_FLUSH: next_state = S_EVENT;
      S_EVENT: next_state = (ev_valid && is_vectored(ev_type)) ? S_DELIVER : S_FINISH;
      S_DELIVER: if (deliver_done) next_state = S_FINISH;
      S_HOST: next_state = S_IDLE;
      S_FINISH: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state <= S_IDLE;
    else
      state <= next_state;
  end

  // Pointer entries and list walking.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pte_i <= 2'd0;
      list_i <= 32'h0;
      ent_lo <= 64'h0;
      ent_hi <= 64'h0;
      fail_idx <= 32'h0;
      pte_guest_phys <= 1'b0;
      for (int i = 0; i < PTE_COUNT; i++) pointer_table_entry[i] <= 64'h0;
    end
    else
    begin
      if (start)
      begin
        pte_i <= 2'd0;
        list_i <= 32'h0;
      end
      if (state == S_PTE && ctrl[B_SLT])
      begin
        for (int i = 0; i < PTE_COUNT; i++) pointer_table_entry[i] <= guest_pte_field[i];
        pte_guest_phys <= 1'b1;
      end
      else if (state == S_PTE && mem_rd_ack)
      begin
        pointer_table_entry[pte_i] <= mem_rd_data;
        pte_guest_phys <= 1'b0;
        pte_i <= pte_i + 2'd1;
      end
      if (state == S_LIST_LO && mem_rd_ack && !list_end) ent_lo <= mem_rd_data;
      if (state == S_LIST_HI && mem_rd_ack) ent_hi <= mem_rd_data;
      if (state == S_CHECK && chk_bus.reject) fail_idx <= list_i;
      if (state == S_WRITE && msr_wr_ready) list_i <= list_i + 32'h1;
    end
  end

  // Memory read requests hold until acknowledged.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mem_rd_req <= 1'b0;
      mem_rd_addr <= 64'h0;
    end
    else if (state == S_LIST_LO && mem_rd_ack && !list_end)
    begin
      // The high word follows straight on, so the request stays up across the low word's answer.
      mem_rd_req <= 1'b1;
      mem_rd_addr <= list_addr + PTE_STRIDE;
    end
    else if (mem_rd_req && mem_rd_ack)
      mem_rd_req <= 1'b0;
    else if (state == S_PTE && !ctrl[B_SLT] && !mem_rd_req)
    begin
      mem_rd_req <= 1'b1;
      mem_rd_addr <= ptb + (PTE_STRIDE * {62'h0, pte_i});
    end
    else if (state == S_LIST_LO && !list_end && !mem_rd_req)
    begin
      mem_rd_req <= 1'b1;
      mem_rd_addr <= list_addr;
    end
  end

  // Side effects of the sequence: one-cycle pulses, plus root and vector values that hold.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tlb_inv_tag_zero <= 1'b0;
      tlb_inv_tag <= TAG_ZERO;
      tlb_inv_root <= 40'h0;
      tlb_flush_all <= 1'b0;
      requesting_virq_vector <= 8'h00;
      servicing_virq_vector <= 8'h00;
      processor_priority_update <= 1'b0;
      virq_evaluate <= 1'b0;
      monitor_clear <= 1'b0;
      host_state_load <= 1'b0;
      single_step_trap <= 1'b0;
      flush_due <= 1'b0;
    end
    else
    begin
      // Only untagged translations are dropped; guest-physical ones may stay.
      tlb_inv_tag_zero <= (state == S_TLB) && !ctrl[B_TAG];
      tlb_inv_tag <= TAG_ZERO;
      if (state == S_TLB) tlb_inv_root <= slp[ROOT_MSB:ROOT_LSB];
      if (state == S_VIRQ_LD)
      begin
        requesting_virq_vector <= irq_stat[7:0];
        servicing_virq_vector <= irq_stat[15:8];
      end
      processor_priority_update <= (state == S_VIRQ_PPR);
      virq_evaluate <= (state == S_VIRQ_EVAL);
      monitor_clear <= (state == S_MON);
      host_state_load <= entry_fail;
      single_step_trap <= (state == S_EVENT) && ev_valid && ev_type == EV_OTHER && ev_vec == 8'h00;
      if (start) flush_due <= 1'b0;
      else if (state == S_WRITE && msr_wr_ready && msr_needs_flush) flush_due <= 1'b1;
      tlb_flush_all <= (state == S_FLUSH) && flush_due;
    end
  end

  // Register write port, event delivery and nested handling.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      msr_wr_valid <= 1'b0;
      msr_wr_index <= 32'h0;
      msr_wr_data <= 64'h0;
      deliver_req <= 1'b0;
      deliver_vector <= 8'h00;
      deliver_type <= 3'h0;
      nested_deliver <= 1'b0;
      double_fault <= 1'b0;
      guest_exit <= 1'b0;
    end
    else
    begin
      msr_wr_valid <= (next_state == S_WRITE) && !(state == S_WRITE && msr_wr_ready);
      if (state == S_CHECK)
      begin
        msr_wr_index <= ent_lo[31:0];
        msr_wr_data <= wr_value;
      end
      deliver_req <= (next_state == S_DELIVER) && !deliver_done;
      if (state == S_EVENT)
      begin
        deliver_vector <= ev_vec;
        deliver_type <= ev_type;
      end
      nested_deliver <= (state == S_DELIVER) && deliver_done && nested_valid && !exc_hit;
      double_fault <= (state == S_DELIVER) && deliver_done && nested_valid && !exc_hit
                   && nested_class != CLS_BENIGN && inj_class != CLS_BENIGN;
      guest_exit <= event_exit;
    end
  end

  logic mon_seen;
  always_ff @(posedge clk)
  begin
    if (srst || start)
      mon_seen <= 1'b0;
    else if (monitor_clear)
      mon_seen <= 1'b1;
  end

  property p_pte_pae;
    @(posedge clk) disable iff (srst)
    (state == S_PTE) |-> (ctrl[B_PAE] && !ctrl[B_LMA]);
  endproperty
  a_pte_pae: assert property (p_pte_pae) else $error("pointer load outside extension mode");

  property p_inv_tag;
    @(posedge clk) disable iff (srst)
    (state == S_TLB) |=> (tlb_inv_tag_zero == !ctrl[B_TAG]) && (tlb_inv_root == slp[ROOT_MSB:ROOT_LSB]);
  endproperty
  a_inv_tag: assert property (p_inv_tag) else $error("tag zero invalidation wrong");

  property p_virq_order;
    @(posedge clk) disable iff (srst)
    (state == S_VIRQ_LD) |=> ##1 processor_priority_update ##1 virq_evaluate;
  endproperty
  a_virq_order: assert property (p_virq_order) else $error("virq sequence out of order");

  property p_mon;
    @(posedge clk) disable iff (srst)
    entry_done |-> mon_seen;
  endproperty
  a_mon: assert property (p_mon) else $error("entry finished without monitor clear");

  property p_fail_host;
    @(posedge clk) disable iff (srst)
    (state == S_CHECK && chk_bus.reject) |-> ##2 host_state_load && status[ST_FAIL];
  endproperty
  a_fail_host: assert property (p_fail_host) else $error("rejected entry did not load host");

  property p_mode_keep;
    @(posedge clk) disable iff (srst)
    (state == S_CHECK && msr_is_mode_reg) |=> msr_wr_data[LMA_BIT] == $past(msr_cur_value[LMA_BIT]);
  endproperty
  a_mode_keep: assert property (p_mode_keep) else $error("long-mode flag changed by list");

  property p_after_list;
    @(posedge clk) disable iff (srst)
    deliver_req |-> list_end && !msr_wr_valid;
  endproperty
  a_after_list: assert property (p_after_list) else $error("event before list complete");

  property p_sstep;
    @(posedge clk) disable iff (srst)
    single_step_trap |-> $past(ev_type) == EV_OTHER && $past(ev_vec) == 8'h00 && !deliver_req;
  endproperty
  a_sstep: assert property (p_sstep) else $error("single-step trap without type 7 vector 0");

  property p_exit;
    @(posedge clk) disable iff (srst)
    (state == S_DELIVER && deliver_done && nested_valid) |=> (guest_exit == $past(exc_hit)) && (nested_deliver != guest_exit);
  endproperty
  a_exit: assert property (p_exit) else $error("nested exception routed wrongly");

  property p_flush;
    @(posedge clk) disable iff (srst)
    (state == S_WRITE && msr_wr_ready && msr_needs_flush) |-> ##[1:300] tlb_flush_all || host_state_load;
  endproperty
  a_flush: assert property (p_flush) else $error("flush missing after list write");
endmodule : guest_entry_late_stage_sequencer
`default_nettype wire

// ---- pkg/gels_pkg.sv ----
`default_nettype none
package gels_pkg;
  // Avalon byte offsets.
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_STATUS = 6'h04;
  localparam logic [5:0] OFS_PTB_LO = 6'h08;
  localparam logic [5:0] OFS_PTB_HI = 6'h0C;
  localparam logic [5:0] OFS_LIST_LO = 6'h10;
  localparam logic [5:0] OFS_LIST_HI = 6'h14;
  localparam logic [5:0] OFS_LIST_CNT = 6'h18;
  localparam logic [5:0] OFS_EVENT = 6'h1C;
  localparam logic [5:0] OFS_SLP_LO = 6'h20;
  localparam logic [5:0] OFS_SLP_HI = 6'h24;
  localparam logic [5:0] OFS_IRQ_STAT = 6'h28;
  localparam logic [5:0] OFS_EXC_MAP = 6'h2C;
  localparam logic [5:0] OFS_FAIL_IDX = 6'h30;
  // Control bits.
  localparam int B_START = 0;
  localparam int B_SLT = 1;
  localparam int B_TAG = 2;
  localparam int B_VIRQ = 3;
  localparam int B_PAE = 4;
  localparam int B_LMA = 5;
  localparam int B_SMM = 6;
  localparam logic [6:0] CTRL_RST = 7'h00;
  // Status bits.
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_SSTEP = 3;
  localparam int ST_EXIT = 4;
  // Event information field.
  localparam int EV_VALID = 31;
  localparam int EV_TYPE_LSB = 8;
  localparam logic [2:0] EV_EXT = 3'h0;
  localparam logic [2:0] EV_NMI = 3'h2;
  localparam logic [2:0] EV_HWEXC = 3'h3;
  localparam logic [2:0] EV_SWINT = 3'h4;
  localparam logic [2:0] EV_PRIVSW = 3'h5;
  localparam logic [2:0] EV_SWEXC = 3'h6;
  localparam logic [2:0] EV_OTHER = 3'h7;
  // Pointer table and translation tagging.
  localparam int PTE_COUNT = 4;
  localparam logic [63:0] PTE_STRIDE = 64'h0000_0000_0000_0008;
  localparam logic [15:0] TAG_ZERO = 16'h0000;
  localparam int ROOT_MSB = 51;
  localparam int ROOT_LSB = 12;
  // Register-load list.
  localparam logic [63:0] LIST_STRIDE = 64'h0000_0000_0000_0010;
  localparam logic [31:0] IDX_FS_BASE = 32'hC000_0100;
  localparam logic [31:0] IDX_GS_BASE = 32'hC000_0101;
  localparam logic [23:0] IDX_APIC_HI = 24'h00_0008;
  localparam logic [31:0] RSV_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {CLS_BENIGN, CLS_CONTRIB, CLS_PAGE} exc_class_t;
endpackage : gels_pkg
`default_nettype wire

// ---- pkg/entry_check_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface entry_check_if (input wire logic clk, input wire logic srst);
  logic [31:0] index;
  logic [31:0] reserved;
  logic in_smm;
  logic smm_only;
  logic forbidden;
  logic gp_fault;
  logic reject;
  modport seq (output index, reserved, in_smm, smm_only, forbidden, gp_fault, input reject, clk, srst);
  modport chk (input index, reserved, in_smm, smm_only, forbidden, gp_fault, clk, srst, output reject);
endinterface : entry_check_if
`default_nettype wire

// ---- hw/list_entry_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module list_entry_checker
  import gels_pkg::*;
(
  entry_check_if.chk c
);
  wire seg_base = (c.index == IDX_FS_BASE) || (c.index == IDX_GS_BASE);
  wire apic_range = (c.index[31:8] == IDX_APIC_HI);
  wire smm_bad = c.smm_only && !c.in_smm;
  wire rsv_bad = (c.reserved != RSV_ZERO);
  assign c.reject = seg_base || apic_range || smm_bad || c.forbidden || rsv_bad || c.gp_fault;

  property p_rsv;
    @(posedge c.clk) disable iff (c.srst)
    (c.reserved != RSV_ZERO) |-> c.reject;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set but entry taken");

  property p_apic;
    @(posedge c.clk) disable iff (c.srst)
    (c.index[31:8] == IDX_APIC_HI) |-> c.reject;
  endproperty
  a_apic: assert property (p_apic) else $error("controller range entry taken");

  property p_clean;
    @(posedge c.clk) disable iff (c.srst)
    (!seg_base && !apic_range && !c.smm_only && !c.forbidden && c.reserved == RSV_ZERO && !c.gp_fault)
      |-> !c.reject;
  endproperty
  a_clean: assert property (p_clean) else $error("clean entry rejected");
endmodule : list_entry_checker
`default_nettype wire

// ---- bench/guest_entry_late_stage_sequencer_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module guest_entry_late_stage_sequencer_tb
  import gels_pkg::*;
;
  logic clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, st, s;
  logic avs_waitrequest, mem_rd_req, mem_rd_ack = 1'b0, msr_wr_valid, msr_wr_ready = 1'b0;
  logic [63:0] mem_rd_addr, mem_rd_data = 64'h0, msr_wr_data, img [32], gpf [PTE_COUNT], pte [PTE_COUNT];
  logic [63:0] wdat [4];
  logic [31:0] msr_wr_index, widx [4];
  logic pte_guest_phys, tlb_inv_tag_zero, tlb_flush_all, processor_priority_update, virq_evaluate;
  logic monitor_clear, deliver_req, deliver_done = 1'b0, nv = 1'b0, nested_deliver, double_fault;
  logic guest_exit, single_step_trap, host_state_load;
  logic [15:0] tlb_inv_tag;
  logic [39:0] tlb_inv_root;
  logic [7:0] rvv, svv, deliver_vector, dvec;
  logic [2:0] deliver_type, dtype;
  logic [4:0] fl = 5'h00;
  logic [10:0] p;
  exc_class_t nc = CLS_BENIGN, ic = CLS_BENIGN;
  int cnt [11], n_wr, n_del, wr_at_del, failures = 0, n_compared = 0;
  // Register flags answer for the second list entry only, so the first one always lands.
  wire logic [4:0] fx = (n_wr > 0) ? fl : 5'h00;
  localparam logic [31:0] IX [7] = '{32'hC000_0100, 32'hC000_0101, 32'h0000_0812, 32'h11, 32'h11, 32'h11, 32'h11};
  assign p = {mem_rd_ack, virq_evaluate, processor_priority_update, tlb_flush_all, single_step_trap,
    double_fault, nested_deliver, guest_exit, host_state_load, tlb_inv_tag_zero, monitor_clear};
  guest_entry_late_stage_sequencer u_guest_entry_late_stage_sequencer (.clk(clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_rd_req(mem_rd_req),
    .mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data), .guest_pte_field(gpf),
    .pointer_table_entry(pte), .pte_guest_phys(pte_guest_phys), .tlb_inv_tag_zero(tlb_inv_tag_zero),
    .tlb_inv_tag(tlb_inv_tag), .tlb_inv_root(tlb_inv_root), .tlb_flush_all(tlb_flush_all),
    .requesting_virq_vector(rvv), .servicing_virq_vector(svv),
    .processor_priority_update(processor_priority_update), .virq_evaluate(virq_evaluate),
    .monitor_clear(monitor_clear), .msr_wr_valid(msr_wr_valid), .msr_wr_index(msr_wr_index),
    .msr_wr_data(msr_wr_data), .msr_wr_ready(msr_wr_ready), .msr_smm_only(fx[0]), .msr_forbidden(fx[1]),
    .msr_gp_fault(fx[2]), .msr_needs_flush(fx[3]), .msr_is_mode_reg(fx[4]), .msr_cur_value(64'h400),
    .deliver_req(deliver_req), .deliver_vector(deliver_vector), .deliver_type(deliver_type),
    .deliver_done(deliver_done), .nested_valid(nv), .nested_vector(5'h0D), .nested_class(nc), .inj_class(ic),
    .nested_deliver(nested_deliver), .double_fault(double_fault), .guest_exit(guest_exit),
    .single_step_trap(single_step_trap), .host_state_load(host_state_load));
  initial
  begin
    forever #4 clk = ~clk;
  end
  // Released data lines flip so that a late sample cannot pass for the real word.
  always @(posedge clk)
  begin
    mem_rd_ack <= mem_rd_req && !mem_rd_ack;
    mem_rd_data <= mem_rd_ack ? ~mem_rd_data : img[mem_rd_addr[7:3]];
    msr_wr_ready <= msr_wr_valid && !msr_wr_ready;
    deliver_done <= deliver_req && !deliver_done;
    for (int i = 0; i < 11; i++)
      cnt[i] += p[i];
    if (msr_wr_valid && msr_wr_ready && n_wr < 4)
    begin
      widx[n_wr] = msr_wr_index;
      wdat[n_wr] = msr_wr_data;
      n_wr++;
    end
    if (deliver_req && deliver_done)
    begin
      n_del++;
      dtype = deliver_type;
      dvec = deliver_vector;
      wr_at_del = n_wr;
    end
  end
  task automatic bus(input logic [5:0] a, input logic [31:0] d, input logic w, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, d, 1'b1, q);
  endtask : wr
  task automatic chk(input logic [191:0] g, input logic [191:0] e);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic run(input logic [6:0] c, input logic [31:0] ev, input logic [31:0] n);
    foreach (cnt[i])
      cnt[i] = 0;
    n_wr = 0;
    n_del = 0;
    wr(OFS_LIST_CNT, n);
    wr(OFS_EVENT, ev);
    wr(OFS_CTRL, {25'h0, c} | 32'h1);
    repeat (100)
    begin
      bus(OFS_STATUS, 32'h0, 1'b0, st);
      if (st[ST_DONE] === 1'b1)
        break;
    end
    wr(OFS_STATUS, 32'h1E);
  endtask : run
  task final_report;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  initial
  begin
    #400000;
    failures++;
    final_report;
  end
  initial
  begin
    for (int i = 0; i < 32; i++)
      img[i] = 64'h5A00_0000_0000_1000 + i;
    for (int i = 0; i < 4; i++)
      gpf[i] = 64'h0000_0000_0000_7000 + i;
    img[8] = 64'h10;
    img[9] = 64'hAAAA;
    img[10] = 64'h11;
    img[11] = 64'hBBBB;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    wr(OFS_LIST_LO, 32'h40);
    wr(OFS_SLP_LO, 32'h5000);
    wr(OFS_SLP_HI, 32'h1);
    wr(OFS_IRQ_STAT, 32'h2A1B);
    bus(6'h3C, 32'h0, 1'b0, s);
    chk(s, 0);
    run(7'h10, 32'h0, 32'h2);
    for (int i = 0; i < 4; i++)
      chk(pte[i], img[i]);
    chk({pte_guest_phys, cnt[10]}, {1'b0, 32'd8});
    chk({cnt[1], tlb_inv_tag, tlb_inv_root}, {32'd1, 16'h0, 40'h00_0010_0005});
    chk({cnt[0], st[ST_FAIL]}, {32'd1, 1'b0});
    chk({widx[0], widx[1], wdat[0], wdat[1]}, {32'h10, 32'h11, 64'hAAAA, 64'hBBBB});
    run(7'h1E, 32'h0, 32'h2);
    for (int i = 0; i < 4; i++)
      chk({pte[i], pte_guest_phys}, {gpf[i], 1'b1});
    chk({cnt[1], cnt[10]}, {32'd0, 32'd4});
    chk({rvv, svv, cnt[8], cnt[9]}, {8'h1B, 8'h2A, 32'd1, 32'd1});
    run(7'h30, 32'h0, 32'h2);
    chk({cnt[10], cnt[0]}, {32'd4, 32'd1});
    $display("test paging and caches done");
    for (int i = 0; i < 7; i++)
    begin
      img[10] = {(i == 3) ? 32'h1 : 32'h0, IX[i]};
      fl = (i > 3) ? 5'h01 << (i - 4) : 5'h00;
      run(7'h00, 32'h0, 32'h2);
      chk({st[ST_FAIL], n_wr}, {1'b1, 32'd1});
      bus(OFS_FAIL_IDX, 32'h0, 1'b0, s);
      chk({s, cnt[2]}, {32'd1, 32'd1});
    end
    img[10] = 64'h11;
    fl = 5'h18;
    run(7'h00, 32'h0, 32'h2);
    chk(cnt[7], 1);
    chk(wdat[1], 64'hBFBB);
    fl = 5'h00;
    $display("test register list done");
    for (int t = 0; t < 8; t++)
    begin
      run(7'h00, {1'b1, 20'h0, t[2:0], (t == 7) ? 8'h00 : 8'h21}, 32'h2);
      chk(n_del, t != 1 && t != 7);
      if (t != 1 && t != 7)
        chk({dtype, dvec, wr_at_del}, {t[2:0], 8'h21, 32'd2});
      chk({cnt[6], st[ST_SSTEP]}, {t == 7, t == 7});
    end
    nv = 1'b1;
    wr(OFS_EXC_MAP, 32'h2000);
    run(7'h00, 32'h8000_030E, 32'h0);
    chk({cnt[3], cnt[4], st[ST_EXIT]}, {32'd1, 32'd0, 1'b1});
    wr(OFS_EXC_MAP, 32'h0);
    nc = CLS_CONTRIB;
    ic = CLS_CONTRIB;
    run(7'h00, 32'h8000_030E, 32'h0);
    chk({cnt[3], cnt[4], cnt[5]}, {32'd0, 32'd1, 32'd1});
    $display("test event injection done");
    final_report;
  end
endmodule : guest_entry_late_stage_sequencer_tb
`default_nettype wire
